// ===== scb_pkg.sv
/*
  Shared constants and types of the stepper chopper blanking and polarity PWM block.
  It assumes a 20 MHz bus clock, an AHB-Lite register port, and a chopper oscillator
  that arrives as a plain level synchronous to that clock.
*/
// Overview of operation
// - Current mode: end on phase at target
// - Standalone: direction from polarity pins
// - Blanking masks comparators after switching
// - Blank selects choose 0.6 to 1.5 us
// - Polarity change restarts that bridge cycle
// - Bridges chopped on opposite clock edges
// - Overcurrent detection off during blanking
package scb_pkg;

  // Clock and blank times
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLANK_LL_NS   = 600;
  localparam int BLANK_LH_NS   = 900;
  localparam int BLANK_HL_NS   = 1200;
  localparam int BLANK_HH_NS   = 1500;
  localparam int BLANK_W       = 6;
  // Least times round up to whole cycles
  localparam logic [BLANK_W-1:0] BLANK_LL_CYC =
    BLANK_W'((BLANK_LL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_LH_CYC =
    BLANK_W'((BLANK_LH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_HL_CYC =
    BLANK_W'((BLANK_HL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_HH_CYC =
    BLANK_W'((BLANK_HH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CYCLES_OFS = 8'h08;

  // Control fields
  localparam int CTRL_STANDALONE = 0;
  localparam int CTRL_ENABLE     = 1;
  localparam int CTRL_DIR_A      = 2;
  localparam int CTRL_DIR_B      = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_000F;

  // Status fields
  localparam int STAT_A_ON    = 0;
  localparam int STAT_A_BLANK = 1;
  localparam int STAT_B_ON    = 2;
  localparam int STAT_B_BLANK = 3;
  localparam int STAT_A_DIR   = 4;
  localparam int STAT_B_DIR   = 5;
  localparam int STAT_MDA_N   = 6;
  localparam int STAT_MDB_N   = 7;
  localparam int STAT_BSEL    = 8;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

  localparam int NUM_COILS = 2;

  // Per bridge drive state seen by the power stage
  typedef struct packed {
    logic on;        // Bridge in on phase, else decay or idle
    logic dir;       // Current direction
    logic blanking;  // Comparators masked
    logic ocp_en;    // Low side overcurrent detection armed
  } scb_bridge_t;

  // Bridge chopper states
  typedef enum logic [1:0] {SCB_IDLE, SCB_ON, SCB_DECAY} scb_state_t;

  // Decode of the two blank select pins into a cycle count
  function automatic logic [BLANK_W-1:0] scb_blank_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    scb_blank_cycles = BLANK_LL_CYC;
      2'h1:    scb_blank_cycles = BLANK_LH_CYC;
      2'h2:    scb_blank_cycles = BLANK_HL_CYC;
      default: scb_blank_cycles = BLANK_HH_CYC;
    endcase
  endfunction : scb_blank_cycles

endpackage : scb_pkg

// ===== scb_bridge.sv
/*
  One bridge chopper: on phase with blanking, ended by the current comparator.
  Assumes a one-cycle start pulse per chopper period from its parent and
  comparator levels synchronous to hclk.
*/
module scb_bridge (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        enable,
  input  wire logic                        cycle_start,
  input  wire logic                        polarity,
  input  wire logic                        sense_trip,
  input  wire logic [scb_pkg::BLANK_W-1:0] blank_len,
  output scb_pkg::scb_bridge_t             bridge
);
  import scb_pkg::*;

  scb_state_t          state,     next_state;
  logic [BLANK_W-1:0]  blank_cnt, next_blank_cnt;
  logic                dir,       next_dir;
  scb_bridge_t         next_bridge;
  logic                pol_change;

  assign pol_change = (polarity != dir);

  // Next state of the chopper; disable wins over everything, then restart wins over the rest
  always_comb begin
    next_state     = state;
    next_blank_cnt = blank_cnt;
    next_dir       = polarity;
    if (!enable) begin
      next_state     = SCB_IDLE;
      next_blank_cnt = '0;
    end else if (cycle_start || pol_change) begin
      next_state     = SCB_ON;
      next_blank_cnt = blank_len;
    end else if (state == SCB_ON) begin
      if (blank_cnt != '0) begin
        next_blank_cnt = blank_cnt - BLANK_W'(1);
      end else if (sense_trip) begin
        next_state = SCB_DECAY;
      end
    end
    case (next_state)
      SCB_ON:    next_bridge.on = 1'b1;
      SCB_DECAY: next_bridge.on = 1'b0;
      default:   next_bridge.on = 1'b0;
    endcase
    next_bridge.dir      = next_dir;
    next_bridge.blanking = (next_state == SCB_ON) && (next_blank_cnt != '0);
    next_bridge.ocp_en   = (next_state == SCB_ON) && (next_blank_cnt == '0);
  end

  // Registers; outputs come straight from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= SCB_IDLE;
      blank_cnt <= '0;
      dir       <= 1'b0;
      bridge    <= '0;
    end else begin
      state     <= next_state;
      blank_cnt <= next_blank_cnt;
      dir       <= next_dir;
      bridge    <= next_bridge;
    end
  end

endmodule : scb_bridge

// ===== scb_chopper.sv
/*
  Top of the stepper chopper blanking and polarity PWM block with its AHB-Lite
  register port. Assumes one master, a 20 MHz hclk, and chopper oscillator,
  polarity, mixed decay, blank select and comparator pins synchronous to hclk.
*/
module scb_chopper (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Chopper oscillator and pins
  input  wire logic                          chop_osc,
  input  wire logic                          coil_a_polarity,
  input  wire logic                          coil_b_polarity,
  input  wire logic                          coil_a_mixdecay_n,
  input  wire logic                          coil_b_mixdecay_n,
  input  wire logic                          blank_sel_lo,
  input  wire logic                          blank_sel_hi,
  input  wire logic                          coil_a_sense_in,
  input  wire logic                          coil_b_sense_in,
  // Bridge drive
  output scb_pkg::scb_bridge_t               bridge_a,
  output scb_pkg::scb_bridge_t               bridge_b
);
  import scb_pkg::*;

  // Bus state
  logic        wr_pend,  next_wr_pend;
  logic [7:0]  wr_addr,  next_wr_addr;
  logic [31:0] ctrl,     next_ctrl;
  logic [31:0] cycles,   next_cycles;
  logic [31:0] next_hrdata;
  logic        req;

  // Chopper clock edge state
  logic        osc_q,    next_osc_q;
  logic        rise,     fall;

  // Per coil arrays
  logic [NUM_COILS-1:0]        start_v;
  logic [NUM_COILS-1:0]        pol_v;
  logic [NUM_COILS-1:0]        sense_v;
  scb_bridge_t                 br_v [NUM_COILS];
  logic [BLANK_W-1:0]          blank_len;
  logic [1:0]                  bsel;

  // Blank select pins decode into the blank length
  assign bsel      = {blank_sel_hi, blank_sel_lo};
  assign blank_len = scb_blank_cycles(bsel);

  // Edge detection on the oscillator level
  assign rise = chop_osc & ~osc_q;
  assign fall = ~chop_osc & osc_q;

  assign start_v = {fall, rise};
  assign sense_v = {coil_b_sense_in, coil_a_sense_in};

  // Direction source depends on mode
  always_comb begin
    if (ctrl[CTRL_STANDALONE]) begin
      pol_v = {coil_b_polarity, coil_a_polarity};
    end else begin
      pol_v = {ctrl[CTRL_DIR_B], ctrl[CTRL_DIR_A]};
    end
  end

  // One chopper per coil
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COILS; gi = gi + 1) begin : g_coil
      scb_bridge u_bridge (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .enable      (ctrl[CTRL_ENABLE]),
        .cycle_start (start_v[gi]),
        .polarity    (pol_v[gi]),
        .sense_trip  (sense_v[gi]),
        .blank_len   (blank_len),
        .bridge      (br_v[gi])
      );
    end
  endgenerate

  // Bridge drive comes straight from the chopper flops
  assign bridge_a = br_v[0];
  assign bridge_b = br_v[1];

  // A transfer is taken when selected, active and the bus is ready
  assign req = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Bus next values: zero wait state, read data registered at address phase
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_ctrl    = ctrl;
    next_hrdata  = hrdata;
    next_osc_q   = chop_osc;
    next_cycles  = cycles;
    // Write data lands in the cycle after the address phase
    if (wr_pend && wr_addr == CTRL_OFS) begin
      next_ctrl = hwdata & CTRL_MASK;
    end
    // Chopper periods counted only while the bridges run
    if (rise && ctrl[CTRL_ENABLE]) begin
      next_cycles = cycles + 32'h0000_0001;
    end
    if (req) begin
      next_wr_pend = hwrite;
      next_wr_addr = {haddr[7:2], 2'h0};
      if (!hwrite) begin
        case ({haddr[7:2], 2'h0})
          CTRL_OFS:   next_hrdata = ctrl;
          STATUS_OFS: begin
            next_hrdata               = 32'h0000_0000;
            next_hrdata[STAT_A_ON]    = br_v[0].on;
            next_hrdata[STAT_A_BLANK] = br_v[0].blanking;
            next_hrdata[STAT_B_ON]    = br_v[1].on;
            next_hrdata[STAT_B_BLANK] = br_v[1].blanking;
            next_hrdata[STAT_A_DIR]   = br_v[0].dir;
            next_hrdata[STAT_B_DIR]   = br_v[1].dir;
            next_hrdata[STAT_MDA_N]   = coil_a_mixdecay_n;
            next_hrdata[STAT_MDB_N]   = coil_b_mixdecay_n;
            next_hrdata[STAT_BSEL+1:STAT_BSEL] = bsel;
          end
          CYCLES_OFS: next_hrdata = cycles;
          default:    next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus registers; hreadyout and hresp never stall or error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      ctrl      <= CTRL_RESET;
      cycles    <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      osc_q     <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      ctrl      <= next_ctrl;
      cycles    <= next_cycles;
      hrdata    <= next_hrdata;
      osc_q     <= next_osc_q;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule : scb_chopper

// ===== scb_chopper_checker.sv
/* Checker of the scb_chopper bridge timing, blank runs and comparator masking.
   Assumes pins synchronous to hclk; attached by the bind at the foot. */
module scb_chopper_checker (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            chop_osc,
  input  wire logic            blank_sel_lo,
  input  wire logic            blank_sel_hi,
  input  wire logic            coil_a_sense_in,
  input  wire logic            coil_b_sense_in,
  input  scb_pkg::scb_bridge_t bridge_a,
  input  scb_pkg::scb_bridge_t bridge_b
);
  import scb_pkg::*;
  logic [5:0]  cnt_a, cnt_b, next_cnt_a, next_cnt_b, need;
  scb_bridge_t prev_a, prev_b;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Blank run length; a direction flip starts a new run, so restarts only lengthen it
  always_comb begin
    need = 6'((600 + 300 * int'({blank_sel_hi, blank_sel_lo}) + 49) / 50);
    next_cnt_a = !bridge_a.blanking ? 6'h00 :
      (!prev_a.blanking || bridge_a.dir != prev_a.dir) ? 6'h01 : cnt_a + 6'h01;
    next_cnt_b = !bridge_b.blanking ? 6'h00 :
      (!prev_b.blanking || bridge_b.dir != prev_b.dir) ? 6'h01 : cnt_b + 6'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_a <= 6'h00;
      cnt_b <= 6'h00;
      prev_a <= '0;
      prev_b <= '0;
    end else begin
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
      prev_a <= bridge_a;
      prev_b <= bridge_b;
    end
  end
  AST_OCP_OFF_A: assert property (bridge_a.blanking |-> !bridge_a.ocp_en)
    else $error("coil A overcurrent armed while blanking");
  AST_OCP_OFF_B: assert property (bridge_b.blanking |-> !bridge_b.ocp_en)
    else $error("coil B overcurrent armed while blanking");
  AST_ON_BLANKS_A: assert property ($rose(bridge_a.on) |-> bridge_a.blanking)
    else $error("coil A on phase began without blanking");
  AST_END_ON_A: assert property (bridge_a.on && !bridge_a.blanking && coil_a_sense_in
    |-> ##[1:2] (!bridge_a.on || bridge_a.blanking)) else $error("coil A on phase not ended");
  AST_END_ON_B: assert property (bridge_b.on && !bridge_b.blanking && coil_b_sense_in
    |-> ##[1:2] (!bridge_b.on || bridge_b.blanking)) else $error("coil B on phase not ended");
  AST_BLANK_LEN_A: assert property ($fell(bridge_a.blanking) |-> cnt_a >= need)
    else $error("coil A blank run too short");
  AST_BLANK_LEN_B: assert property ($fell(bridge_b.blanking) |-> cnt_b >= need)
    else $error("coil B blank run too short");
  AST_B_ON_FALL: assert property ($fell(chop_osc) && bridge_b.on
    |-> ##[1:3] bridge_b.blanking) else $error("coil B not restarted on falling edge");
  COV_A_END: cover property (bridge_a.on ##1 !bridge_a.on);
  COV_B_BLANK: cover property ($fell(bridge_b.blanking));
  COV_A_FLIP: cover property ($changed(bridge_a.dir));
endmodule : scb_chopper_checker

bind scb_chopper scb_chopper_checker u_checker (.hclk(hclk), .hresetn(hresetn),
  .chop_osc(chop_osc), .blank_sel_lo(blank_sel_lo), .blank_sel_hi(blank_sel_hi),
  .coil_a_sense_in(coil_a_sense_in), .coil_b_sense_in(coil_b_sense_in),
  .bridge_a(bridge_a), .bridge_b(bridge_b));

// ===== scb_mcu_model.sv
/* Controller model: voltage PWM on both polarity pins, mixed decay held off.
   Assumes duty values from the bench and a 128 step period on hclk. */
module scb_mcu_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [6:0] duty_a,
  input  wire logic [6:0] duty_b,
  output logic            coil_a_polarity,
  output logic            coil_b_polarity,
  output logic            coil_a_mixdecay_n,
  output logic            coil_b_mixdecay_n
);
  logic [6:0] cnt, next_cnt;
  // PWM step counter
  // Free running PWM period counter; kept at 7 bits so a polarity edge
  // always comes well inside the bench's wait bound, at the cost of resolution
  always_comb next_cnt = cnt + 7'h01;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 7'h00;
    else cnt <= next_cnt;
  end
  // full swing PWM
  // Coil B shifted half a period; its edges meet coil A's when either duty sits at the half point
  assign coil_a_polarity = cnt < duty_a;
  assign coil_b_polarity = 7'(cnt + 7'h40) < duty_b;
  // offset applies to serial mixed decay only; decay stays off here
  assign coil_a_mixdecay_n = 1'b1;
  assign coil_b_mixdecay_n = 1'b1;
endmodule : scb_mcu_model

// ===== scb_chopper_bench.sv
/* Self-checking bench of scb_chopper with the controller model on the pins.
   Assumes the checker is bound in; registers reached over AHB-Lite. */
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED at %0t: got %h, expected %h", $time, (a), (e)); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 400) begin cyc; n++; end \
  if (n >= 400) begin fails++; finish_test; end end
module scb_chopper_bench import scb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, chop_osc = 0, p;
  logic        coil_a_sense_in = 0, coil_b_sense_in = 0, blank_sel_lo = 0, blank_sel_hi = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, coil_a_polarity, coil_b_polarity;
  logic        coil_a_mixdecay_n, coil_b_mixdecay_n;
  logic [6:0]  duty_a = 7'h40, duty_b = 7'h40;
  scb_bridge_t bridge_a, bridge_b;
  int          fails = 0, checked = 0, n, k, s;
  scb_chopper u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chop_osc, .coil_a_polarity,
    .coil_b_polarity, .coil_a_mixdecay_n, .coil_b_mixdecay_n, .blank_sel_lo, .blank_sel_hi,
    .coil_a_sense_in, .coil_b_sense_in, .bridge_a, .bridge_b);
  scb_mcu_model u_mcu (.hclk, .hresetn, .duty_a, .duty_b, .coil_a_polarity,
    .coil_b_polarity, .coil_a_mixdecay_n, .coil_b_mixdecay_n);
  // 20 MHz clock
  initial forever #25 hclk = ~hclk;
  // Sample just after the edge so flop updates have landed
  task automatic cyc; @(posedge hclk); #1; endtask : cyc
  // One single AHB transfer; read data left in r
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    cyc;
    `WAITFOR(hreadyout === 1'b1)
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    cyc;
    `WAITFOR(hreadyout === 1'b1)
    r = hrdata;
  endtask : ahb
  // Blank cycles from the select code, rounded up to whole cycles
  function automatic int blank_exp(input int sel); return (600 + 300 * sel + 49) / 50;
  endfunction : blank_exp
  // Eight step sine of amplitude 24 about the mid point; cosine is two steps on
  function automatic int wave(input int i);
    int t[8] = '{0, 17, 24, 17, 0, -17, -24, -17};
    return t[i & 7];
  endfunction : wave
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(82918));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped word, enable
    ahb(0, CTRL_OFS, 0); `CHK(r, CTRL_RESET)
    ahb(0, 32'h0000_000C, 0); `CHK(r, 32'h0)
    ahb(0, STATUS_OFS, 0); `CHK(r[7:6], 2'h3)
    `CHK(hresp, HRESP_OKAY)
    ahb(1, CTRL_OFS, 32'h0000_0002);
    ahb(0, CTRL_OFS, 0); `CHK(r, 32'h0000_0002)
    // Every select code; sense held high so only blanking keeps the bridge on
    for (s = 0; s < 4; s++) begin
      @(posedge hclk);
      {blank_sel_hi, blank_sel_lo} <= 2'(s);
      coil_a_sense_in <= 1'b1;
      chop_osc <= 1'b1;
      `WAITFOR(bridge_a.blanking === 1'b1)
      for (k = 0; bridge_a.blanking === 1'b1 && k < 40; k++) cyc;
      `CHK(k, blank_exp(s))
      `CHK({bridge_a.on, bridge_a.ocp_en}, 2'b11)
      cyc;
      if (bridge_a.on === 1'b1) cyc;
      `CHK(bridge_a.on, 1'b0)
      @(posedge hclk);
      chop_osc <= 1'b0;
      repeat (3) cyc;
      `CHK({bridge_b.blanking, bridge_a.on}, 2'b10)
      repeat (40) cyc;
    end
    ahb(0, CYCLES_OFS, 0); `CHK(r, 32'h0000_0004)
    // Standalone: random duty split evenly about the mid point, random sense
    ahb(1, CTRL_OFS, 32'h0000_0003);
    for (s = 0; s < 12; s++) begin
      k = $urandom_range(7, 0);
      duty_a <= 7'(64 + wave(k));
      duty_b <= 7'(64 + wave(k + 2));
      // limit trips only now and then
      coil_a_sense_in <= ($urandom_range(3, 0) == 0);
      coil_b_sense_in <= ($urandom_range(3, 0) == 0);
      p = coil_a_polarity;
      `WAITFOR(coil_a_polarity !== p)
      `WAITFOR(bridge_a.dir === coil_a_polarity)
      `CHK({bridge_a.on, bridge_a.blanking}, 2'b11)
      `CHK(bridge_b.dir, coil_b_polarity)
    end
    finish_test;
  end
endmodule : scb_chopper_bench
